// ### rtl/fd_class_if.sv
// opcode classification bundle between decoder and classifier
// assumes a purely combinational classifier on the far side
`timescale 1ns/1ps
`default_nettype none
interface fd_class_if;
  import fd_pkg::*;
  logic [OPC_W-1:0] opcode;
  fd_group_t        group;
  logic             two_word;
  logic [CYC_W-1:0] extra;
  logic             is_cond;
  logic             is_skip;
  modport user (output opcode, input group, two_word, extra, is_cond,
                input is_skip);
  modport cls  (input opcode, output group, two_word, extra, is_cond,
                output is_skip);
endinterface : fd_class_if
`default_nettype wire

// ### rtl/fd_classify.sv
// opcode classifier: group, word count and cycle cost of an opcode
// assumes the opcode is stable for the cycle it is looked at
`timescale 1ns/1ps
`default_nettype none
module fd_classify (
  fd_class_if.cls c
);
  import fd_pkg::*;

  always_comb begin
    c.group    = fd_group_t'(c.opcode[OPC_W-1 -: 2]);
    c.two_word = 1'b0;
    c.extra    = EXTRA_NONE;
    c.is_cond  = 1'b0;
    c.is_skip  = 1'b0;
    if (c.group == GRP_CTRL) begin
      unique case (c.opcode)
        OP_GOTO_LONG,
        OP_CALL_LONG,
        OP_LOAD_LONG: begin
          c.two_word = 1'b1;
        end
        OP_MOVE_DOUBLE: begin
          c.extra = EXTRA_FLOW;
        end
        OP_RELATIVE_BRANCH,
        OP_COMPUTED_BRANCH,
        OP_CALL_INDIRECT,
        OP_JUMP_INDIRECT,
        OP_TABLE_READ,
        OP_TABLE_WRITE: begin
          c.extra = EXTRA_FLOW;
        end
        OP_SUB_RETURN,
        OP_INTERRUPT_RETURN: begin
          c.extra = EXTRA_RETURN;
        end
        OP_COND_BRANCH: begin
          c.is_cond = 1'b1;
        end
        OP_SKIP: begin
          c.is_skip = 1'b1;
        end
        default: begin
          c.extra = EXTRA_NONE;
        end
      endcase
    end
  end
endmodule : fd_classify
`default_nettype wire

// ### rtl/fd_decoder.sv
// instruction format decoder and cycle sequencer
// takes 24-bit words from program memory over a valid/ready handshake,
// issues one decoded slot per instruction cycle (one clk_sys cycle)
// assumes cond_true is the condition result for the word offered
`timescale 1ns/1ps
`default_nettype none
module fd_decoder (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic [fd_pkg::WORD_W-1:0] word_in,
  input  wire logic                     word_valid,
  output logic                          word_ready,
  input  wire logic                     cond_true,
  output logic                          exec_valid,
  output logic                          exec_no_op,
  output logic                          exec_two_word,
  output logic                          exec_bad_second,
  output logic [fd_pkg::CYC_W-1:0]      exec_cycles,
  output logic [fd_pkg::INSTR_W-1:0]    exec_instr,
  output logic [fd_pkg::OPC_W-1:0]      exec_opcode,
  output fd_pkg::fd_group_t             exec_group,
  output logic [fd_pkg::DEFAULT_WORK_REG_W-1:0]     base_src_reg,
  output logic [fd_pkg::DEFAULT_WORK_REG_W-1:0]     second_src_reg,
  output logic [fd_pkg::MODE_W-1:0]     second_src_mode,
  output logic [fd_pkg::DEFAULT_WORK_REG_W-1:0]     dest_reg,
  output logic [fd_pkg::MODE_W-1:0]     dest_mode,
  output logic [fd_pkg::FILE_W-1:0]     file_addr,
  output logic                          dest_is_file,
  output logic                          byte_mode,
  output logic [fd_pkg::DEFAULT_WORK_REG_W-1:0]     bit_pos,
  output logic                          bit_from_reg,
  output logic                          target_is_file,
  output logic [fd_pkg::LIT_W-1:0]      literal
);
  import fd_pkg::*;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_WORD2 = 3'b010,
    ST_STALL = 3'b100
  } fd_state_t;

  fd_state_t           state_ff;
  fd_state_t           nxt_state_ff;
  logic [CYC_W-1:0]    cnt_ff;
  logic [CYC_W-1:0]    nxt_cnt_ff;
  logic                kill_ff;
  logic                nxt_kill_ff;
  logic                kill2_ff;
  logic                nxt_kill2_ff;
  logic [WORD_W-1:0]   first_ff;
  logic [WORD_W-1:0]   nxt_first_ff;
  fd_fields_t          pend_ff;
  fd_fields_t          nxt_pend_ff;
  fd_fields_t          fields_ff;
  fd_fields_t          nxt_fields_ff;
  logic [INSTR_W-1:0]  instr_ff;
  logic [INSTR_W-1:0]  nxt_instr_ff;
  logic                valid_ff;
  logic                nxt_valid_ff;
  logic                no_op_ff;
  logic                nxt_no_op_ff;
  logic                two_ff;
  logic                nxt_two_ff;
  logic                bad2_ff;
  logic                nxt_bad2_ff;
  logic [CYC_W-1:0]    cycles_ff;
  logic [CYC_W-1:0]    nxt_cycles_ff;
  logic [CYC_W-1:0]    extra;
  fd_fields_t          dec;

  fd_class_if cls_if ();

  fd_classify u_classify (
    .c (cls_if.cls)
  );

  assign cls_if.opcode = word_in[OPC_LSB +: OPC_W];

  // operand split depends only on the group and flag bits of the opcode
  function automatic fd_fields_t decode_fields(
    input logic [WORD_W-1:0] w,
    input fd_group_t         g
  );
    fd_fields_t f;
    f        = '0;
    f.opcode = w[OPC_LSB +: OPC_W];
    f.group  = g;
    unique case (g)
      GRP_WORD: begin
        if (w[WB_FILE_FORM_POS]) begin
          f.file_addr    = w[FR_ADDR_LSB +: FILE_W];
          f.dest_is_file = w[FR_DEST_POS];
          f.byte_mode    = w[FR_BYTE_POS];
          f.dest_reg     = DEFAULT_WORK_REG;
        end else begin
          f.base_src_reg    = w[WR_BASE_LSB +: DEFAULT_WORK_REG_W];
          f.second_src_reg  = w[WR_SRC_LSB +: DEFAULT_WORK_REG_W];
          f.second_src_mode = w[WR_SMODE_LSB +: MODE_W];
          f.dest_reg        = w[WR_DEST_LSB +: DEFAULT_WORK_REG_W];
          f.dest_mode       = w[WR_DMODE_LSB +: MODE_W];
        end
      end
      GRP_BIT: begin
        f.target_is_file = w[BT_FILE_POS];
        f.bit_from_reg   = w[BT_IND_POS];
        // one field: literal bit number, or the register that holds it
        if (w[BT_IND_POS]) begin
          f.base_src_reg = w[BT_POS_LSB +: DEFAULT_WORK_REG_W];
        end else begin
          f.bit_pos = w[BT_POS_LSB +: DEFAULT_WORK_REG_W];
        end
        if (w[BT_FILE_POS]) begin
          f.file_addr = {1'b0, w[0 +: BT_FILE_W]};
        end else begin
          f.second_src_reg  = w[WR_SRC_LSB +: DEFAULT_WORK_REG_W];
          f.second_src_mode = w[WR_SMODE_LSB +: MODE_W];
        end
      end
      GRP_LIT: begin
        f.base_src_reg = w[WR_BASE_LSB +: DEFAULT_WORK_REG_W];
        f.literal      = w[LT_LIT_LSB +: LIT_W];
        // without its own field the result lands back in the base
        if (w[LT_SEP_POS]) begin
          f.dest_reg = w[LT_DEST_LSB +: DEFAULT_WORK_REG_W];
        end else begin
          f.dest_reg = w[WR_BASE_LSB +: DEFAULT_WORK_REG_W];
        end
      end
      GRP_CTRL: begin
        f.literal = w[LT_LIT_LSB +: LIT_W];
      end
    endcase
    return f;
  endfunction : decode_fields

  assign dec   = decode_fields(word_in, cls_if.group);
  assign extra = CYC_W'(cls_if.extra + {1'b0, cls_if.is_cond & cond_true});

  always_comb begin
    nxt_state_ff  = state_ff;
    nxt_cnt_ff    = cnt_ff;
    nxt_kill_ff   = kill_ff;
    nxt_kill2_ff  = kill2_ff;
    nxt_first_ff  = first_ff;
    nxt_pend_ff   = pend_ff;
    nxt_fields_ff = fields_ff;
    nxt_instr_ff  = instr_ff;
    nxt_valid_ff  = 1'b0;
    nxt_no_op_ff  = no_op_ff;
    nxt_two_ff    = two_ff;
    nxt_bad2_ff   = bad2_ff;
    nxt_cycles_ff = cycles_ff;
    word_ready    = 1'b0;
    unique case (state_ff)
      ST_FETCH: begin
        word_ready = 1'b1;
        if (word_valid) begin
          nxt_bad2_ff = 1'b0;
          if (kill_ff) begin
            // skipped word burns its cycle as a no-operation
            nxt_kill_ff   = 1'b0;
            nxt_valid_ff  = 1'b1;
            nxt_no_op_ff  = 1'b1;
            nxt_two_ff    = 1'b0;
            nxt_cycles_ff = CYC_ONE;
            nxt_fields_ff = '0;
            nxt_instr_ff  = {{WORD_W{1'b0}}, word_in};
            if (cls_if.two_word) begin
              nxt_kill2_ff = 1'b1;
              nxt_state_ff = ST_WORD2;
            end
          end else if (cls_if.two_word) begin
            nxt_first_ff = word_in;
            nxt_pend_ff  = dec;
            nxt_state_ff = ST_WORD2;
          end else begin
            nxt_valid_ff  = 1'b1;
            nxt_fields_ff = dec;
            nxt_instr_ff  = {{WORD_W{1'b0}}, word_in};
            nxt_two_ff    = 1'b0;
            // a lone second word carries opcode zero
            nxt_no_op_ff  = (dec.opcode == OP_NO_OPERATION);
            nxt_cycles_ff = CYC_W'(CYC_ONE + extra);
            nxt_kill_ff   = cls_if.is_skip & cond_true;
            if (extra != EXTRA_NONE) begin
              nxt_cnt_ff   = extra;
              nxt_state_ff = ST_STALL;
            end
          end
        end
      end
      ST_WORD2: begin
        word_ready = 1'b1;
        if (word_valid) begin
          nxt_valid_ff  = 1'b1;
          nxt_state_ff  = ST_FETCH;
          nxt_cycles_ff = CYC_ONE;
          if (kill2_ff) begin
            nxt_kill2_ff  = 1'b0;
            nxt_no_op_ff  = 1'b1;
            nxt_two_ff    = 1'b0;
            nxt_fields_ff = '0;
            nxt_instr_ff  = {{WORD_W{1'b0}}, word_in};
          end else begin
            nxt_no_op_ff  = 1'b0;
            nxt_two_ff    = 1'b1;
            nxt_cycles_ff = CYC_TWO;
            nxt_fields_ff = pend_ff;
            nxt_instr_ff  = {first_ff, word_in};
            // upper byte must be zero; flagged rather than trusted
            nxt_bad2_ff   = |word_in[OPC_LSB +: OPC_W];
          end
        end
      end
      ST_STALL: begin
        // memory is held off while the filler cycles run
        nxt_valid_ff = 1'b1;
        nxt_no_op_ff = 1'b1;
        nxt_two_ff   = 1'b0;
        nxt_cnt_ff   = CYC_W'(cnt_ff - CYC_ONE);
        if (cnt_ff == CYC_ONE) begin
          nxt_state_ff = ST_FETCH;
        end
      end
      default: begin
        nxt_state_ff = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff  <= ST_FETCH;
      cnt_ff    <= '0;
      kill_ff   <= 1'b0;
      kill2_ff  <= 1'b0;
      first_ff  <= '0;
      pend_ff   <= '0;
      fields_ff <= '0;
      instr_ff  <= '0;
      valid_ff  <= 1'b0;
      no_op_ff  <= 1'b0;
      two_ff    <= 1'b0;
      bad2_ff   <= 1'b0;
      cycles_ff <= '0;
    end else begin
      state_ff  <= nxt_state_ff;
      cnt_ff    <= nxt_cnt_ff;
      kill_ff   <= nxt_kill_ff;
      kill2_ff  <= nxt_kill2_ff;
      first_ff  <= nxt_first_ff;
      pend_ff   <= nxt_pend_ff;
      fields_ff <= nxt_fields_ff;
      instr_ff  <= nxt_instr_ff;
      valid_ff  <= nxt_valid_ff;
      no_op_ff  <= nxt_no_op_ff;
      two_ff    <= nxt_two_ff;
      bad2_ff   <= nxt_bad2_ff;
      cycles_ff <= nxt_cycles_ff;
    end
  end

  assign exec_valid      = valid_ff;
  assign exec_no_op      = no_op_ff;
  assign exec_two_word   = two_ff;
  assign exec_bad_second = bad2_ff;
  assign exec_cycles     = cycles_ff;
  assign exec_instr      = instr_ff;
  assign exec_opcode     = fields_ff.opcode;
  assign exec_group      = fields_ff.group;
  assign base_src_reg    = fields_ff.base_src_reg;
  assign second_src_reg  = fields_ff.second_src_reg;
  assign second_src_mode = fields_ff.second_src_mode;
  assign dest_reg        = fields_ff.dest_reg;
  assign dest_mode       = fields_ff.dest_mode;
  assign file_addr       = fields_ff.file_addr;
  assign dest_is_file    = fields_ff.dest_is_file;
  assign byte_mode       = fields_ff.byte_mode;
  assign bit_pos         = fields_ff.bit_pos;
  assign bit_from_reg    = fields_ff.bit_from_reg;
  assign target_is_file  = fields_ff.target_is_file;
  assign literal         = fields_ff.literal;
endmodule : fd_decoder
`default_nettype wire

// ### rtl/fd_pkg.sv
// constants, field layout and opcode map of the instruction format decoder
// assumes at most one word arrives per clk_sys cycle from program memory
package fd_pkg;
  localparam int WORD_W   = 24;
  localparam int OPC_W    = 8;
  localparam int OPC_LSB  = 16;
  localparam int INSTR_W  = 48;
  localparam int DEFAULT_WORK_REG_W   = 4;
  localparam int FILE_W   = 13;
  localparam int LIT_W    = 8;
  localparam int MODE_W   = 2;
  localparam int CYC_W    = 2;

  // operand field positions inside a word
  localparam int WB_FILE_FORM_POS = 21;
  localparam int FR_BYTE_POS      = 15;
  localparam int FR_DEST_POS      = 14;
  localparam int FR_ADDR_LSB      = 0;
  localparam int WR_BASE_LSB      = 12;
  localparam int WR_DMODE_LSB     = 10;
  localparam int WR_DEST_LSB      = 6;
  localparam int WR_SMODE_LSB     = 4;
  localparam int WR_SRC_LSB       = 0;
  localparam int BT_FILE_POS      = 17;
  localparam int BT_IND_POS       = 16;
  localparam int BT_POS_LSB       = 12;
  localparam int BT_FILE_W        = 12;
  localparam int LT_SEP_POS       = 16;
  localparam int LT_DEST_LSB      = 8;
  localparam int LT_LIT_LSB       = 0;

  localparam logic [DEFAULT_WORK_REG_W-1:0] DEFAULT_WORK_REG = 4'h0;

  typedef enum logic [1:0] {
    GRP_CTRL = 2'h0,
    GRP_WORD = 2'h1,
    GRP_BIT  = 2'h2,
    GRP_LIT  = 2'h3
  } fd_group_t;

  localparam logic [OPC_W-1:0] OP_NO_OPERATION     = 8'h00;
  localparam logic [OPC_W-1:0] OP_GOTO_LONG        = 8'h02;
  localparam logic [OPC_W-1:0] OP_CALL_LONG        = 8'h03;
  localparam logic [OPC_W-1:0] OP_LOAD_LONG        = 8'h04;
  localparam logic [OPC_W-1:0] OP_MOVE_DOUBLE      = 8'h08;
  localparam logic [OPC_W-1:0] OP_RELATIVE_BRANCH  = 8'h10;
  localparam logic [OPC_W-1:0] OP_COMPUTED_BRANCH  = 8'h11;
  localparam logic [OPC_W-1:0] OP_CALL_INDIRECT    = 8'h12;
  localparam logic [OPC_W-1:0] OP_JUMP_INDIRECT    = 8'h13;
  localparam logic [OPC_W-1:0] OP_TABLE_READ       = 8'h14;
  localparam logic [OPC_W-1:0] OP_TABLE_WRITE      = 8'h15;
  localparam logic [OPC_W-1:0] OP_SUB_RETURN       = 8'h16;
  localparam logic [OPC_W-1:0] OP_INTERRUPT_RETURN = 8'h17;
  localparam logic [OPC_W-1:0] OP_COND_BRANCH      = 8'h18;
  localparam logic [OPC_W-1:0] OP_SKIP             = 8'h19;

  // extra cycles beyond the first, then whole cycle counts
  localparam logic [CYC_W-1:0] EXTRA_NONE   = 2'h0;
  localparam logic [CYC_W-1:0] EXTRA_FLOW   = 2'h1;
  localparam logic [CYC_W-1:0] EXTRA_RETURN = 2'h2;
  localparam logic [CYC_W-1:0] CYC_ONE      = 2'h1;
  localparam logic [CYC_W-1:0] CYC_TWO      = 2'h2;

  typedef struct packed {
    logic [OPC_W-1:0]  opcode;
    fd_group_t         group;
    logic [DEFAULT_WORK_REG_W-1:0] base_src_reg;
    logic [DEFAULT_WORK_REG_W-1:0] second_src_reg;
    logic [MODE_W-1:0] second_src_mode;
    logic [DEFAULT_WORK_REG_W-1:0] dest_reg;
    logic [MODE_W-1:0] dest_mode;
    logic [FILE_W-1:0] file_addr;
    logic              dest_is_file;
    logic              byte_mode;
    logic [DEFAULT_WORK_REG_W-1:0] bit_pos;
    logic              bit_from_reg;
    logic              target_is_file;
    logic [LIT_W-1:0]  literal;
  } fd_fields_t;
endpackage : fd_pkg

// ### test/fd_decoder_props.sv
// checker for slot timing and field extraction of the decoder
// assumes it is bound to fd_decoder and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module fd_decoder_props
  import fd_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               reset_n,
  input wire logic               word_ready,
  input wire logic               exec_valid,
  input wire logic               exec_no_op,
  input wire logic               exec_two_word,
  input wire logic               exec_bad_second,
  input wire logic [CYC_W-1:0]   exec_cycles,
  input wire logic [INSTR_W-1:0] exec_instr,
  input wire logic [OPC_W-1:0]   exec_opcode,
  input wire fd_group_t          exec_group,
  input wire logic [DEFAULT_WORK_REG_W-1:0]  base_src_reg,
  input wire logic [DEFAULT_WORK_REG_W-1:0]  second_src_reg,
  input wire logic [DEFAULT_WORK_REG_W-1:0]  dest_reg,
  input wire logic [FILE_W-1:0]  file_addr,
  input wire logic               bit_from_reg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic slot;
  assign slot = exec_valid && !exec_no_op;

  AST_RETURN_THREE: assert property (
    slot && exec_opcode inside {8'h16, 8'h17}
    |-> exec_cycles == 2'h3 && !word_ready
    ##1 exec_valid && exec_no_op && !word_ready
    ##1 exec_valid && exec_no_op && word_ready)
    else $error("return slot timing wrong");
  AST_FLOW_TWO: assert property (
    slot && exec_opcode inside {8'h08, [8'h10:8'h15]}
    |-> exec_cycles == 2'h2 && !word_ready
    ##1 exec_valid && exec_no_op && word_ready)
    else $error("branch or table slot timing wrong");
  AST_COND_TAKEN: assert property (
    slot && exec_opcode == 8'h18 && exec_cycles == 2'h2
    |-> !word_ready ##1 exec_valid && exec_no_op)
    else $error("taken condition lacks filler");
  AST_ONE_CYCLE: assert property (
    slot && !exec_two_word && exec_cycles == 2'h1 |-> word_ready)
    else $error("one cycle slot stalled");
  AST_JOIN: assert property (
    exec_valid && exec_two_word |-> exec_cycles == 2'h2
    && exec_instr[47:40] inside {[8'h02:8'h04]}
    && exec_bad_second == (exec_instr[23:16] != 8'h00))
    else $error("joined slot wrong");
  AST_FIRST_SILENT: assert property (
    exec_valid && exec_two_word |-> !$past(exec_valid))
    else $error("first word answered");
  AST_GROUP: assert property (
    slot |-> exec_group == fd_group_t'(exec_opcode[7:6]))
    else $error("group not from opcode");
  AST_FILE_FORM: assert property (
    slot && exec_group == GRP_WORD && exec_instr[21]
    |-> file_addr == exec_instr[12:0] && dest_reg == DEFAULT_WORK_REG)
    else $error("file form fields wrong");
  AST_REG_FORM: assert property (
    slot && exec_group == GRP_WORD && !exec_instr[21]
    |-> base_src_reg == exec_instr[15:12] && dest_reg == exec_instr[9:6]
    && second_src_reg == exec_instr[3:0])
    else $error("register form fields wrong");
  AST_LIT_DEST: assert property (
    slot && exec_group == GRP_LIT && !exec_instr[16]
    |-> dest_reg == base_src_reg)
    else $error("literal destination wrong");
  AST_BIT_SRC: assert property (
    slot && exec_group == GRP_BIT && exec_instr[16]
    |-> bit_from_reg && base_src_reg == exec_instr[15:12])
    else $error("bit number source wrong");
  AST_STRAY: assert property (
    exec_valid && exec_instr[47:16] == 32'h0 |-> exec_no_op)
    else $error("stray second word executed");

  cover property (slot && exec_opcode == 8'h16);
  cover property (exec_valid && exec_two_word);
  cover property (slot && exec_opcode == 8'h19 ##1 exec_valid);
endmodule : fd_decoder_props

bind fd_decoder fd_decoder_props u_props (.clk_sys, .reset_n, .word_ready,
  .exec_valid, .exec_no_op, .exec_two_word, .exec_bad_second, .exec_cycles,
  .exec_instr, .exec_opcode, .exec_group, .base_src_reg, .second_src_reg,
  .dest_reg, .file_addr, .bit_from_reg);
`default_nettype wire

// ### test/fd_prog_mem.sv
// program memory model offering queued words over valid/ready
// assumes the bench fills wq and cq; offers change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module fd_prog_mem (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        word_ready,
  input  wire logic [7:0]  slow_pct,
  output logic      [23:0] word_in,
  output logic             word_valid,
  output logic             cond_true
);
  logic [23:0] wq[$];
  logic        cq[$];
  logic        rdy_prev;
  logic        took;
  logic        hold;
  initial begin
    word_in = 24'h5a5a5a;
    word_valid = 1'b0;
    cond_true = 1'b0;
    rdy_prev = 1'b0;
  end
  // ready only moves after a rising edge, so seen here it holds till the next
  always @(negedge clk_sys) begin
    took = word_valid && rdy_prev && reset_n;
    hold = word_valid && !rdy_prev && reset_n;
    rdy_prev = word_ready;
    if (took) begin
      void'(wq.pop_front());
      void'(cq.pop_front());
    end
    if (!hold) begin
      if (reset_n && wq.size() > 0 && $urandom_range(99) >= slow_pct) begin
        word_valid <= 1'b1;
        word_in <= wq[0];
        cond_true <= cq[0];
      end else begin
        // idle lines toggle so a stale value is never mistaken for data
        word_valid <= 1'b0;
        word_in <= ~word_in;
        cond_true <= ~cond_true;
      end
    end
  end
endmodule : fd_prog_mem
`default_nettype wire

// ### test/tb_instruction_format_and_cycle_timing.sv
// self-checking bench: queued reference slots against every issued slot
// assumes fd_decoder with the checker bound and fd_prog_mem as supplier
`timescale 1ns/1ps
`default_nettype none
module tb_instruction_format_and_cycle_timing;
  import fd_pkg::*;
  typedef struct {
    bit           no_operation;
    bit           full;
    logic [1:0]   cyc;
    logic         two;
    logic         bad;
    logic [47:0]  instr;
    fd_fields_t   f;
  } fd_exp_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] slow_pct = 8'd0;
  logic [WORD_W-1:0] word_in;
  logic word_valid, word_ready, cond_true, exec_valid, exec_no_op;
  logic exec_two_word, exec_bad_second, dest_is_file, byte_mode;
  logic bit_from_reg, target_is_file;
  logic [CYC_W-1:0] exec_cycles;
  logic [INSTR_W-1:0] exec_instr;
  logic [OPC_W-1:0] exec_opcode;
  fd_group_t exec_group;
  logic [DEFAULT_WORK_REG_W-1:0] base_src_reg, second_src_reg, dest_reg, bit_pos;
  logic [MODE_W-1:0] second_src_mode, dest_mode;
  logic [FILE_W-1:0] file_addr;
  logic [LIT_W-1:0] literal;
  logic [$bits(fd_fields_t)-1:0] got_f;
  fd_exp_t q[$];
  fd_exp_t me;
  logic pend, pk, kill;
  logic [23:0] fw;
  logic [23:0] w;
  int bad_count, tests_run, cyc_cnt, n;
  logic [7:0] ctl [13] = '{8'h00, 8'h05, 8'h08, 8'h10, 8'h11, 8'h12, 8'h13,
                           8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};

  fd_decoder uut (.clk_sys, .reset_n, .word_in, .word_valid, .word_ready,
    .cond_true, .exec_valid, .exec_no_op, .exec_two_word, .exec_bad_second,
    .exec_cycles, .exec_instr, .exec_opcode, .exec_group, .base_src_reg,
    .second_src_reg, .second_src_mode, .dest_reg, .dest_mode, .file_addr,
    .dest_is_file, .byte_mode, .bit_pos, .bit_from_reg, .target_is_file,
    .literal);
  fd_prog_mem mem (.clk_sys, .reset_n, .word_ready, .slow_pct, .word_in,
    .word_valid, .cond_true);

  assign got_f = {exec_opcode, exec_group, base_src_reg, second_src_reg,
    second_src_mode, dest_reg, dest_mode, file_addr, dest_is_file, byte_mode,
    bit_pos, bit_from_reg, target_is_file, literal};

  always #25 clk_sys = ~clk_sys;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic fd_fields_t dec(input logic [23:0] x);
    fd_fields_t f;
    f = '0;
    f.opcode = x[23:16];
    f.group = fd_group_t'(x[23:22]);
    case (x[23:22])
      2'h1: if (x[21]) begin
        f.file_addr = x[12:0];
        f.dest_is_file = x[14];
        f.byte_mode = x[15];
      end else begin
        f.base_src_reg = x[15:12];
        f.dest_mode = x[11:10];
        f.dest_reg = x[9:6];
        f.second_src_mode = x[5:4];
        f.second_src_reg = x[3:0];
      end
      2'h2: begin
        f.target_is_file = x[17];
        f.bit_from_reg = x[16];
        if (x[16]) f.base_src_reg = x[15:12];
        else f.bit_pos = x[15:12];
        if (x[17]) f.file_addr = {1'b0, x[11:0]};
        else f.second_src_reg = x[3:0];
        if (!x[17]) f.second_src_mode = x[5:4];
      end
      2'h3: begin
        f.base_src_reg = x[15:12];
        f.literal = x[7:0];
        f.dest_reg = x[16] ? x[11:8] : x[15:12];
      end
      default: f.literal = x[7:0];
    endcase
    return f;
  endfunction : dec

  // reference: every taken word yields its slots in order
  task automatic put(input logic [23:0] x, input logic c);
    fd_exp_t e;
    int ext;
    e = '{default: '0};
    ext = 0;
    mem.wq.push_back(x);
    mem.cq.push_back(c);
    if (pend) begin
      pend = 1'b0;
      e.full = !pk;
      e.no_operation = pk;
      e.two = 1'b1;
      e.cyc = 2'h2;
      e.bad = (x[23:16] != 8'h00);
      e.instr = {fw, x};
      e.f = dec(fw);
      q.push_back(e);
    end else if (kill || x[23:16] == 8'h00) begin
      e.no_operation = 1'b1;
      q.push_back(e);
      pend = kill && x[23:16] inside {[8'h02:8'h04]};
      pk = 1'b1;
      kill = 1'b0;
    end else if (x[23:16] inside {[8'h02:8'h04]}) begin
      pend = 1'b1;
      pk = 1'b0;
      fw = x;
    end else begin
      if (x[23:16] inside {8'h08, [8'h10:8'h15]} || (x[23:16] == 8'h18 && c))
        ext = 1;
      if (x[23:16] inside {8'h16, 8'h17})
        ext = 2;
      kill = (x[23:16] == 8'h19) && c;
      e.full = 1'b1;
      e.cyc = 2'(ext + 1);
      e.instr = {24'h0, x};
      e.f = dec(x);
      q.push_back(e);
      e.full = 1'b0;
      e.no_operation = 1'b1;
      repeat (ext) q.push_back(e);
    end
  endtask : put

  task automatic drain();
    n = 0;
    while ((q.size() != 0 || mem.wq.size() != 0) && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(64'(q.size()), 64'h0);
  endtask : drain

  always @(negedge clk_sys) begin
    // an unknown valid is treated as a slot so it cannot slip by
    if (reset_n && exec_valid !== 1'b0) begin
      if (q.size() == 0) begin
        chk(64'h1, 64'h0);
      end else begin
        me = q.pop_front();
        chk(exec_no_op, me.no_operation);
        if (me.full) begin
          chk(exec_cycles, me.cyc);
          chk({exec_two_word, exec_bad_second}, {me.two, me.bad});
          chk(exec_instr, me.instr);
          chk(got_f, me.f);
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    {pend, pk, kill} = 3'h0;
    void'($urandom(32'hfcf1));
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    foreach (ctl[i]) begin
      for (int c = 0; c < 2; c++) begin
        put({ctl[i], 16'($urandom)}, c[0]);
        put({8'h5a, 16'($urandom)}, 1'b0);
      end
    end
    for (int op = 2; op < 5; op++) begin
      put({8'(op), 16'($urandom)}, 1'b0);
      put({8'h00, 16'($urandom)}, 1'b0);
      put({8'(op), 16'($urandom)}, 1'b0);
      put({8'h45, 16'($urandom)}, 1'b0);
      put({8'h19, 16'($urandom)}, 1'b1);
      put({8'(op), 16'($urandom)}, 1'b0);
      put({8'h00, 16'($urandom)}, 1'b0);
      put({8'hc3, 16'($urandom)}, 1'b0);
    end
    drain();
    slow_pct = 8'd40;
    repeat (400) begin
      w = 24'($urandom);
      if (w[23:22] == 2'h0)
        w[23:16] = ctl[$urandom_range(12)];
      if (w[23:22] == 2'h0 && $urandom_range(5) == 0)
        w[23:16] = 8'(2 + $urandom_range(2));
      put(w, 1'($urandom));
      if (w[23:16] inside {[8'h02:8'h04]})
        put({8'h00, 16'($urandom)}, 1'b0);
    end
    drain();
    // reset lands in the middle of a return's filler cycles
    slow_pct = 8'd0;
    put({8'h16, 16'($urandom)}, 1'b0);
    n = 0;
    while (q.size() == 3 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    reset_n = 1'b0;
    q.delete();
    {pend, pk, kill} = 3'h0;
    @(negedge clk_sys);
    chk({exec_valid, word_ready}, 64'h1);
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    put({8'h03, 16'($urandom)}, 1'b0);
    put({8'h00, 16'($urandom)}, 1'b0);
    put({8'h7e, 16'($urandom)}, 1'b0);
    drain();
    give_verdict();
  end
endmodule : tb_instruction_format_and_cycle_timing
`default_nettype wire
